/* pkg/smg_pkg.sv */
// package: constants, carriers and state layout of the switch memory guard
// Notes on behaviour
// - user memory is 114K: 48K of ROM space plus 66K of RAM space
// - 48K of RAM is guardable in independent 8K blocks, plus the system area
// - switch 1 guards 4F00-4FFF; 2-4 and 5-7 guard 8000/A000/C000 of both RAM channels
// - with ROM fitted RAM channels become 3 and 4; switch per block unchanged
// - selected ranges are guarded only while the master protect key is on
// - RAM outside the switch map and the user work area are never guarded
// - system data area is 256 bytes at 4F00, guarded by switch 1
// - console select on: channel 1 is console; off: channel 3 is console
// - console select is sampled only after power-up or reset
// - at power-on copy channel 1 8000-80FF to 4F00-4FFF if enabled and signed
// - fixed pattern in channel 1 8000-8004 marks stored system data present
package smg_pkg;

    localparam int ROM_SPACE_KB   = 48;
    localparam int RAM_SPACE_KB   = 66;
    localparam int USER_MEMORY_KB = ROM_SPACE_KB + RAM_SPACE_KB;
    localparam int GUARD_BLOCK_KB = 8;

    localparam logic [15:0] SYS_AREA_BASE = 16'h4F00;
    localparam logic [7:0]  SYS_AREA_PAGE = 8'h4F;
    localparam int          SYS_AREA_LEN  = 256;
    localparam logic [2:0]  RAM_BLOCK_LO  = 3'h4;     // 8000-9FFF
    localparam logic [2:0]  RAM_BLOCK_HI  = 3'h6;     // C000-DFFF
    localparam logic [15:0] ROM_DATA_BASE = 16'h8000;
    localparam int          SIG_LEN       = 5;

    // channel codes on the memory bus: 0..3 stand for channels 1..4
    localparam logic [1:0] CHAN_ONE   = 2'h0;
    localparam logic [1:0] CHAN_TWO   = 2'h1;
    localparam logic [1:0] CHAN_THREE = 2'h2;
    localparam logic [1:0] CHAN_FOUR  = 2'h3;

    // filtered switch vector layout
    localparam int SW_GUARD0  = 0;   // system_area_guard_switch, guard switches 1..7 at 0..6
    localparam int SW_KEY     = 7;
    localparam int SW_CONSOLE = 8;
    localparam int SW_BOOT    = 9;
    localparam int SW_ROM     = 10;
    localparam int SW_WIDTH   = 11;

    localparam int SETTLE_CYCLES = 4;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h04;
    localparam logic [7:0] REG_BLOCKED = 8'h08;
    localparam logic [7:0] REG_LAST    = 8'h0C;

    // status fields above the switch image
    localparam int ST_CONSOLE = 11;
    localparam int ST_BOOTED  = 12;
    localparam int ST_SIGNED  = 13;
    localparam int ST_COPIED  = 14;
    localparam int CTL_CLEAR  = 0;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  chan;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } smg_req_s;

    typedef struct packed {
        logic       ack;
        logic       blocked;
        logic [7:0] rdata;
    } smg_rsp_s;

    typedef enum logic [2:0] {
        ST_SETTLE    = 3'b000,
        ST_SIG_READ  = 3'b001,
        ST_COPY_READ = 3'b010,
        ST_COPY_WRIT = 3'b011,
        ST_RUN       = 3'b100,
        ST_CPU_WAIT  = 3'b101
    } smg_state_e;

    typedef struct packed {
        logic [SW_WIDTH-1:0] sync1;
        logic [SW_WIDTH-1:0] sync2;
        logic [SW_WIDTH-1:0] sync3;
        logic [SW_WIDTH-1:0] sw;
        smg_state_e          state;
        logic [2:0]          settle;
        logic [7:0]          idx;
        logic [7:0]          copy_byte;
        logic                console;
        logic                signed_ok;
        logic                copied;
        smg_req_s            mem;
        smg_rsp_s            cpu;
        logic [31:0]         blocked_count;
        logic [17:0]         last_blocked;
        logic                apb_ready;
        logic [31:0]         prdata;
        logic                pslverr;
    } smg_regs_s;

endpackage : smg_pkg

/* verilog/smg_guard.sv */
// switch memory guard: write blocking, console select and power-on system data copy
`timescale 1ns/1ps
`default_nettype none

module smg_guard #(
    parameter logic [8*smg_pkg::SIG_LEN-1:0] SIGNATURE = 40'h5A_A55A_A55A  // arbitrary marker
) (
    input  wire logic              CLOCK,
    input  wire logic              RST,
    // switches and jumpers, asynchronous to CLOCK
    input  wire logic [6:0]        GUARD_SWITCH,
    input  wire logic              PROTECT_KEY,
    input  wire logic              CONSOLE_SELECT_SWITCH,
    input  wire logic              BOOT_COPY_ENABLE_SWITCH,
    input  wire logic              ROM_FITTED,
    // processor side
    input  wire smg_pkg::smg_req_s CPU_REQ,
    output smg_pkg::smg_rsp_s      CPU_RSP,
    // memory side
    output smg_pkg::smg_req_s      MEM_REQ,
    input  wire smg_pkg::smg_rsp_s MEM_RSP,
    // console routing and boot status
    output logic                   SERIAL_CHANNEL_ONE_CONSOLE,
    output logic                   SERIAL_CHANNEL_THREE_CONSOLE,
    output logic                   BOOT_BUSY,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR
);

    smg_pkg::smg_regs_s s;
    smg_pkg::smg_regs_s next_s;

    // first or second RAM channel number as seen on the bus, shifted when ROM occupies 1 and 2
    function automatic logic [1:0] ram_chan(input logic rom, input logic second);
        logic [1:0] c;
        c = rom ? smg_pkg::CHAN_THREE : smg_pkg::CHAN_ONE;
        if (second) begin
            c = rom ? smg_pkg::CHAN_FOUR : smg_pkg::CHAN_TWO;
        end
        return c;
    endfunction : ram_chan

    // true when a write to chan/addr falls in an armed range
    function automatic logic guard_hit(
        input logic [smg_pkg::SW_WIDTH-1:0] sw,
        input logic [1:0]                   chan,
        input logic [15:0]                  addr
    );
        logic       hit;
        logic [1:0] blk;
        logic       rom;
        hit = 1'b0;
        blk = 2'(addr[15:13] - smg_pkg::RAM_BLOCK_LO);
        rom = sw[smg_pkg::SW_ROM];
        if (addr[15:8] == smg_pkg::SYS_AREA_PAGE) begin
            hit = sw[smg_pkg::SW_GUARD0];
        end else if (addr[15:13] >= smg_pkg::RAM_BLOCK_LO
                     && addr[15:13] <= smg_pkg::RAM_BLOCK_HI) begin
            // each 8K block keeps its own switch on either channel
            if (chan == ram_chan(rom, 1'b0)) begin
                hit = sw[smg_pkg::SW_GUARD0 + 1 + int'(blk)];
            end else if (chan == ram_chan(rom, 1'b1)) begin
                hit = sw[smg_pkg::SW_GUARD0 + 4 + int'(blk)];
            end
        end
        // anything else (work area, unmapped RAM) never guarded
        return hit && sw[smg_pkg::SW_KEY];
    endfunction : guard_hit

    logic [smg_pkg::SW_WIDTH-1:0] pins;
    logic                         apb_access;
    logic                         apb_commit;
    logic [31:0]                  rd_word;
    logic                         rd_err;
    logic                         blocked_now;
    logic                         clear_now;
    logic [7:0]                   sig_byte;

    assign pins = {ROM_FITTED, BOOT_COPY_ENABLE_SWITCH, CONSOLE_SELECT_SWITCH,
                   PROTECT_KEY, GUARD_SWITCH};

    always_comb begin
        next_s      = s;
        blocked_now = 1'b0;
        sig_byte    = SIGNATURE[8*(smg_pkg::SIG_LEN-1)-:8];

        // three-stage pin capture; a bit moves once stages two and three agree
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        for (int i = 0; i < smg_pkg::SW_WIDTH; i++) begin
            if (s.sync2[i] == s.sync3[i]) begin
                next_s.sw[i] = s.sync3[i];
            end
        end

        next_s.cpu.ack     = 1'b0;
        next_s.cpu.blocked = 1'b0;

        case (s.state)
            smg_pkg::ST_SETTLE: begin
                // wait until the filtered switches reflect the pins
                if (s.settle == 3'(smg_pkg::SETTLE_CYCLES)) begin
                    next_s.console = s.sw[smg_pkg::SW_CONSOLE];
                    next_s.idx     = 8'h00;
                    if (s.sw[smg_pkg::SW_BOOT]) begin
                        next_s.state = smg_pkg::ST_SIG_READ;
                    end else begin
                        next_s.state = smg_pkg::ST_RUN;
                    end
                end else begin
                    next_s.settle = 3'(s.settle + 3'h1);
                end
            end
            smg_pkg::ST_SIG_READ: begin
                sig_byte = SIGNATURE[8*(smg_pkg::SIG_LEN-1-int'(s.idx[2:0]))+:8];
                if (!s.mem.valid) begin
                    next_s.mem.valid = 1'b1;
                    next_s.mem.write = 1'b0;
                    next_s.mem.chan  = smg_pkg::CHAN_ONE;
                    next_s.mem.addr  = smg_pkg::ROM_DATA_BASE + {8'h00, s.idx};
                end else if (MEM_RSP.ack) begin
                    next_s.mem.valid = 1'b0;
                    if (MEM_RSP.rdata != sig_byte) begin
                        next_s.state = smg_pkg::ST_RUN;
                    end else if (s.idx == 8'(smg_pkg::SIG_LEN - 1)) begin
                        next_s.signed_ok = 1'b1;
                        next_s.idx       = 8'h00;
                        next_s.state     = smg_pkg::ST_COPY_READ;
                    end else begin
                        next_s.idx = 8'(s.idx + 8'h01);
                    end
                end
            end
            smg_pkg::ST_COPY_READ: begin
                if (!s.mem.valid) begin
                    next_s.mem.valid = 1'b1;
                    next_s.mem.write = 1'b0;
                    next_s.mem.chan  = smg_pkg::CHAN_ONE;
                    next_s.mem.addr  = smg_pkg::ROM_DATA_BASE + {8'h00, s.idx};
                end else if (MEM_RSP.ack) begin
                    next_s.mem.valid = 1'b0;
                    next_s.copy_byte = MEM_RSP.rdata;
                    next_s.state     = smg_pkg::ST_COPY_WRIT;
                end
            end
            smg_pkg::ST_COPY_WRIT: begin
                // the copy itself bypasses the guard: it is how the area gets filled
                if (!s.mem.valid) begin
                    next_s.mem.valid = 1'b1;
                    next_s.mem.write = 1'b1;
                    next_s.mem.chan  = ram_chan(s.sw[smg_pkg::SW_ROM], 1'b0);
                    next_s.mem.addr  = smg_pkg::SYS_AREA_BASE + {8'h00, s.idx};
                    next_s.mem.wdata = s.copy_byte;
                end else if (MEM_RSP.ack) begin
                    next_s.mem.valid = 1'b0;
                    if (s.idx == 8'(smg_pkg::SYS_AREA_LEN - 1)) begin
                        next_s.copied = 1'b1;
                        next_s.state  = smg_pkg::ST_RUN;
                    end else begin
                        next_s.idx   = 8'(s.idx + 8'h01);
                        next_s.state = smg_pkg::ST_COPY_READ;
                    end
                end
            end
            smg_pkg::ST_RUN: begin
                // a request is taken while valid and no ack is showing
                if (CPU_REQ.valid && !s.cpu.ack) begin
                    if (CPU_REQ.write && guard_hit(s.sw, CPU_REQ.chan, CPU_REQ.addr)) begin
                        next_s.cpu.ack     = 1'b1;
                        next_s.cpu.blocked = 1'b1;
                        next_s.cpu.rdata   = 8'h00;
                        next_s.last_blocked = {CPU_REQ.chan, CPU_REQ.addr};
                        blocked_now         = 1'b1;
                    end else begin
                        next_s.mem   = CPU_REQ;
                        next_s.state = smg_pkg::ST_CPU_WAIT;
                    end
                end
            end
            smg_pkg::ST_CPU_WAIT: begin
                if (MEM_RSP.ack) begin
                    next_s.mem.valid = 1'b0;
                    next_s.cpu.ack   = 1'b1;
                    next_s.cpu.rdata = MEM_RSP.rdata;
                    next_s.state     = smg_pkg::ST_RUN;
                end
            end
            default: begin
                next_s.mem.valid = 1'b0;
                next_s.state     = smg_pkg::ST_RUN;
            end
        endcase

        // APB: one wait state, data latched when pready is raised
        apb_access = PSEL && PENABLE;
        apb_commit = apb_access && s.apb_ready;
        rd_word    = 32'h0000_0000;
        rd_err     = 1'b0;
        case (PADDR)
            smg_pkg::REG_STATUS: begin
                rd_word[smg_pkg::SW_WIDTH-1:0] = s.sw;
                rd_word[smg_pkg::ST_CONSOLE]   = s.console;
                rd_word[smg_pkg::ST_BOOTED]    = s.state[2];
                rd_word[smg_pkg::ST_SIGNED]    = s.signed_ok;
                rd_word[smg_pkg::ST_COPIED]    = s.copied;
            end
            smg_pkg::REG_CONTROL: begin
                rd_word = 32'h0000_0000;
            end
            smg_pkg::REG_BLOCKED: begin
                rd_word = s.blocked_count;
            end
            smg_pkg::REG_LAST: begin
                rd_word[17:0] = s.last_blocked;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
        next_s.apb_ready = apb_access && !s.apb_ready;
        if (apb_access && !s.apb_ready) begin
            next_s.prdata  = PWRITE ? 32'h0000_0000 : rd_word;
            next_s.pslverr = rd_err;
        end
        clear_now = apb_commit && PWRITE && PADDR == smg_pkg::REG_CONTROL
                    && PWDATA[smg_pkg::CTL_CLEAR];
        // a blocked write in the clear cycle still counts
        if (blocked_now) begin
            next_s.blocked_count = clear_now ? 32'h0000_0001 : 32'(s.blocked_count + 32'h1);
        end else if (clear_now) begin
            next_s.blocked_count = 32'h0000_0000;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign CPU_RSP                      = s.cpu;
    assign MEM_REQ                      = s.mem;
    assign SERIAL_CHANNEL_ONE_CONSOLE   = s.console;
    assign SERIAL_CHANNEL_THREE_CONSOLE = !s.console;
    assign BOOT_BUSY                    = !s.state[2];
    assign PRDATA                       = s.prdata;
    assign PREADY                       = s.apb_ready;
    assign PSLVERR                      = s.pslverr;

endmodule : smg_guard

`default_nettype wire

/* testbench/smg_mem_model.sv */
// partner model: byte memory of four channels behind the guard
`timescale 1ns/1ps
`default_nettype none

module smg_mem_model #(
    parameter logic [39:0] SIGNATURE = 40'h00_0000_0000
) (
    input  wire logic              clock,
    input  wire smg_pkg::smg_req_s req,
    input  wire logic [1:0]        slow,
    input  wire logic              rom,
    output smg_pkg::smg_rsp_s      rsp
);
    logic [7:0] mem [0:262143];
    logic [1:0] cnt;

    initial begin
        rsp = '0;
        cnt = '0;
        for (int j = 0; j < 256; j++) begin
            mem[18'h0_8000 + 18'(j)] = j < 5 ? SIGNATURE[39 - 8 * j -: 8] : 8'(j) ^ 8'h3C;
        end
    end

    // idle data is inverted each cycle so a stale byte never looks valid
    always @(posedge clock) begin
        if (rsp.ack || !req.valid) begin
            rsp.ack   <= 1'b0;
            cnt       <= 2'h0;
            rsp.rdata <= ~rsp.rdata;
        end else if (cnt < slow) begin
            cnt <= cnt + 2'h1;
        end else begin
            rsp.ack   <= 1'b1;
            rsp.rdata <= mem[{req.chan, req.addr}];
            // fitted rom keeps its content
            if (req.write && !(rom && !req.chan[1])) begin
                mem[{req.chan, req.addr}] <= req.wdata;
            end
        end
    end
endmodule : smg_mem_model

`default_nettype wire

/* testbench/smg_guard_props.sv */
// checker: port-level properties of the switch memory guard
`timescale 1ns/1ps
`default_nettype none

module smg_guard_props (
    input wire logic              CLOCK,
    input wire logic              RST,
    input wire logic              PROTECT_KEY,
    input wire smg_pkg::smg_req_s CPU_REQ,
    input wire smg_pkg::smg_rsp_s CPU_RSP,
    input wire smg_pkg::smg_req_s MEM_REQ,
    input wire smg_pkg::smg_rsp_s MEM_RSP,
    input wire logic              SERIAL_CHANNEL_ONE_CONSOLE,
    input wire logic              SERIAL_CHANNEL_THREE_CONSOLE,
    input wire logic              BOOT_BUSY,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PREADY
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    console_pair_a: assert property (
        SERIAL_CHANNEL_ONE_CONSOLE != SERIAL_CHANNEL_THREE_CONSOLE) else $error("console pair");
    console_hold_a: assert property (
        !BOOT_BUSY && !$past(BOOT_BUSY) |-> $stable(SERIAL_CHANNEL_ONE_CONSOLE))
        else $error("console changed while running");
    boot_copy_a: assert property (
        BOOT_BUSY && MEM_REQ.valid |-> (MEM_REQ.write ? MEM_REQ.addr[15:8] == 8'h4F
        : MEM_REQ.chan == smg_pkg::CHAN_ONE && MEM_REQ.addr[15:8] == 8'h80))
        else $error("boot access out of range");
    busy_refuse_a: assert property (
        BOOT_BUSY |-> !CPU_RSP.ack) else $error("cpu answered during boot");
    blocked_shape_a: assert property (
        CPU_RSP.blocked |-> CPU_RSP.ack && CPU_RSP.rdata == 8'h00 && CPU_REQ.write)
        else $error("bad blocked answer");
    blocked_range_a: assert property (
        CPU_RSP.blocked |-> CPU_REQ.addr[15:8] == 8'h4F || CPU_REQ.addr[15:13] inside
        {3'h4, 3'h5, 3'h6}) else $error("block outside switch map");
    blocked_key_a: assert property (
        CPU_RSP.blocked |-> PROTECT_KEY) else $error("block with key off");
    mem_follow_a: assert property (
        MEM_REQ.valid && !BOOT_BUSY |-> MEM_REQ == CPU_REQ) else $error("memory request differs");
    read_data_a: assert property (
        MEM_RSP.ack && MEM_REQ.valid && !MEM_REQ.write && !BOOT_BUSY |=> CPU_RSP.ack
        && !CPU_RSP.blocked && CPU_RSP.rdata == $past(MEM_RSP.rdata)) else $error("read lost");
    apb_wait_a: assert property (
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY) else $error("apb wait state");
endmodule : smg_guard_props

bind smg_guard smg_guard_props u_props (.CLOCK(CLOCK), .RST(RST), .PROTECT_KEY(PROTECT_KEY),
    .CPU_REQ(CPU_REQ), .CPU_RSP(CPU_RSP), .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP),
    .SERIAL_CHANNEL_ONE_CONSOLE(SERIAL_CHANNEL_ONE_CONSOLE),
    .SERIAL_CHANNEL_THREE_CONSOLE(SERIAL_CHANNEL_THREE_CONSOLE), .BOOT_BUSY(BOOT_BUSY),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY));

`default_nettype wire

/* testbench/tb.sv */
// testbench: boot copy, console latch, write guard and register checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin fails++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end

module tb;
    localparam logic [39:0] SIG = 40'h5A_A55A_A55A;  // arbitrary marker value
    logic              clock = 0, rst = 1, key = 0, con = 1, boot = 1, rom = 0;
    logic [6:0]        gsw = '0;
    logic [1:0]        slow = '0;
    logic              psel = 0, penable = 0, pwrite = 0, pready, pslverr, busy;
    logic              cons_one, cons_three;
    logic [7:0]        paddr = '0;
    logic [31:0]       pwdata = '0, prdata;
    smg_pkg::smg_req_s cpu_req = '0, mem_req;
    smg_pkg::smg_rsp_s cpu_rsp, mem_rsp;
    logic [15:0]       lfsr = 16'h000E;
    logic [7:0]        hi [5] = '{8'h4F, 8'h9F, 8'hA3, 8'hC8, 8'hE1};
    int                fails = 0, checks_done = 0, nblk = 0;
    logic [17:0]       last_exp = '0;

    always #10 clock = ~clock;

    smg_guard #(.SIGNATURE(SIG)) u_dut (.CLOCK(clock), .RST(rst), .GUARD_SWITCH(gsw),
        .PROTECT_KEY(key), .CONSOLE_SELECT_SWITCH(con), .BOOT_COPY_ENABLE_SWITCH(boot),
        .ROM_FITTED(rom), .CPU_REQ(cpu_req), .CPU_RSP(cpu_rsp), .MEM_REQ(mem_req),
        .MEM_RSP(mem_rsp), .SERIAL_CHANNEL_ONE_CONSOLE(cons_one),
        .SERIAL_CHANNEL_THREE_CONSOLE(cons_three),
        .BOOT_BUSY(busy), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    smg_mem_model #(.SIGNATURE(SIG)) u_mem (.clock(clock), .req(mem_req), .slow(slow),
        .rom(rom), .rsp(mem_rsp));

    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step

    function automatic logic [7:0] rom_byte(input int j);
        return j < 5 ? SIG[39 - 8 * j -: 8] : 8'(j) ^ 8'h3C;
    endfunction : rom_byte

    function automatic logic exp_blk(input logic [6:0] s, input logic k, input logic r,
                                     input logic [1:0] c, input logic [15:0] a);
        logic [1:0] c1;
        c1 = r ? 2'h2 : 2'h0;
        if (!k) return 1'b0;
        if (a[15:8] == 8'h4F) return s[0];
        if (a[15:13] < 3'h4 || a[15:13] > 3'h6) return 1'b0;
        if (c == c1) return s[a[15:13] - 3'h3];
        if (c == c1 + 2'h1) return s[a[15:13]];
        return 1'b0;
    endfunction : exp_blk

    task automatic reboot;
        int n;
        n = 0;
        rst <= 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 5000) fails++;
    endtask : reboot

    task automatic cpu(input logic w, input logic [1:0] c, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q, output logic b);
        int n;
        n = 0;
        cpu_req <= '{1'b1, w, c, a, d};
        @(posedge clock);
        while (cpu_rsp.ack !== 1'b1 && n < 200) begin
            @(posedge clock);
            n++;
        end
        if (n >= 200) fails++;
        q = cpu_rsp.rdata;
        b = cpu_rsp.blocked;
        cpu_req <= '{1'b0, ~w, c, ~a, ~d};
        @(posedge clock);
    endtask : cpu

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        if (n >= 50) fails++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic test_done;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    initial begin
        logic [7:0]  q0, q1, d;
        logic        b0, b1, eb, e;
        logic [31:0] r;
        logic [15:0] a;
        logic [1:0]  c;
        reboot();
        `CHK("console one", 1'b1, cons_one)
        `CHK("console three", 1'b0, cons_three)
        for (int j = 0; j < 256; j += 51) begin
            cpu(1'b0, 2'h0, 16'h4F00 + 16'(j), 8'h00, q0, b0);
            `CHK("copy", rom_byte(j), q0)
        end
        con <= 1'b0;
        repeat (10) @(posedge clock);
        `CHK("latch", 1'b1, cons_one)
        $display("done: boot and console");
        // random switch settings; slow memory stalls mixed in
        for (int i = 0; i < 40; i++) begin
            lfsr = step(lfsr);
            gsw <= i == 0 ? 7'h7F : lfsr[6:0];
            key <= i == 0 ? 1'b1 : lfsr[7];
            rom <= lfsr[8];
            slow <= lfsr[10:9];
            repeat (8) @(posedge clock);
            for (int k = 0; k < 4; k++) begin
                lfsr = step(lfsr);
                c = 2'(k);
                a = {hi[lfsr[15:8] % 5], lfsr[7:0]};
                d = lfsr[11:4];
                eb = exp_blk(gsw, key, rom, c, a);
                cpu(1'b0, c, a, 8'h00, q0, b0);
                cpu(1'b1, c, a, d, q1, b1);
                `CHK("blocked", eb, b1)
                cpu(1'b0, c, a, 8'h00, q1, b0);
                `CHK("stored", (eb || (rom && !c[1])) ? q0 : d, q1)
                nblk += int'(eb);
                if (eb) last_exp = {c, a};
            end
        end
        apb(1'b0, smg_pkg::REG_STATUS, '0, r, e);
        `CHK("status", {4'hF, rom, boot, con, key, gsw}, r[14:0])
        apb(1'b0, smg_pkg::REG_BLOCKED, '0, r, e);
        `CHK("count", 32'(nblk), r)
        apb(1'b0, smg_pkg::REG_LAST, '0, r, e);
        `CHK("last", last_exp, r[17:0])
        apb(1'b1, smg_pkg::REG_CONTROL, 32'h0000_0001, r, e);
        apb(1'b0, smg_pkg::REG_BLOCKED, '0, r, e);
        `CHK("cleared", 32'h0000_0000, r)
        apb(1'b0, 8'h10, '0, r, e);
        `CHK("unmapped", 1'b1, e)
        $display("done: guard and registers");
        key <= 1'b0;
        rom <= 1'b0;
        repeat (8) @(posedge clock);
        cpu(1'b1, 2'h0, 16'h4F10, 8'h77, q0, b0);
        // pass 0: copy switch off; pass 1: switch on, marker broken
        for (int p = 0; p < 2; p++) begin
            con <= p[0];
            boot <= p[0];
            if (p == 1) cpu(1'b1, 2'h0, 16'h8004, ~rom_byte(4), q0, b0);
            reboot();
            `CHK("console", p[0], cons_one)
            cpu(1'b0, 2'h0, 16'h4F10, 8'h00, q0, b0);
            `CHK("no copy", 8'h77, q0)
        end
        $display("done: copy refused");
        test_done();
    end

    initial begin
        #(20 * 80000);
        fails++;
        test_done();
    end
endmodule : tb

`default_nettype wire
